/* logic/fcl_cfg.svh */
// constants for the fir coefficient loader
`ifndef FCL_CFG_SVH
`define FCL_CFG_SVH
`define FCL_CTRL1_ADDR     16'h0001
`define FCL_CTRL1_RESET    16'h001A
`define FCL_BIT_LOAD_REQ   15
`define FCL_BIT_RD_OVR     14
`define FCL_BIT_RD_STAT    11
`define FCL_BIT_SYNC       9
`define FCL_TAP_HI         8
`define FCL_TAP_LO         5
`define FCL_SELF_CLR_MASK  16'h01FF
`define FCL_BIT_MATCH      7
`define FCL_BIT_USER       5
`define FCL_MAX_COEF       48
`define FCL_COEF_STEP      6
`define FCL_FILL_NUM       1
`define FCL_FILL_DEN       2
`endif

/* logic/fcl_pkg.sv */
// types for the fir coefficient loader
package fcl_pkg;
  typedef enum logic [2:0] {
    FCL_ADDR,
    FCL_DATA,
    FCL_COEF_HI,
    FCL_COEF_LO,
    FCL_CHECK,
    FCL_FILL
  } fcl_state_t;
endpackage : fcl_pkg

/* logic/fcl_coef_ram.sv */
// coefficient storage, 48 words of 27 bits, registered read
`timescale 1ns/1ps
module fcl_coef_ram (
  input  wire logic        clock,
  input  wire logic        we,
  input  wire logic [5:0]  waddr,
  input  wire logic [26:0] wdata,
  input  wire logic [5:0]  raddr,
  output logic      [26:0] rdata
);
  logic [26:0] mem [0:47];

  // plain ram, no reset; contents are meaningless until loaded or filled
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : fcl_coef_ram

/* logic/fcl_loader.sv */
// fir coefficient loader: register port, download sequencer, checksum, storage
// Operation
// R1: host loads only even length symmetric fir filters
// R2: coefficient is sign bit plus 26 bit magnitude, sign zero positive
// R3: host chooses 12 to 96 taps in steps of twelve
// R4: only half the taps arrive; the filter mirrors the stored half
// R5: coefficients arrive centre first, moving outward
// R6: host scales the half sum to 67108863
// R7: each coefficient is two words: sign and mag 25:16, then mag 15:0
// R8: checksum is 16 bit sum of all bytes of padded words
// R9: device computes checksum, compares, sets match flag in status bit 7
// R10: host arms load by writing control 1 with request and tap code
// R11: host sends upper word, lower word per coefficient, then checksum
// R12: host checks match flag via status read
// R13: loaded coefficients lost on reset; default filter applies again
// R14: tap code 0 default, odd codes give 6 to 48 coefficients
// R15: unused slots zero filled, half a clock each, after the checksum; the sequencer takes a full clock per slot
// R16: each register write is address word then data word
// R17: control 1 sits at address 1, resets to 0x001A
// R18: status select write returns status on the next read
// R19: while armed every write is coefficient data
// R20: bits 15 to 9 of control 1 clear themselves
// R21: status select makes the next read return status
// R22: host sets at most one readback select per write
// R23: checksum keeps low 16 bits, carry dropped
// R24: an incomplete load never sets the match flag
`timescale 1ns/1ps
`include "fcl_cfg.svh"
module fcl_loader (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_strobe,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  input  wire logic [15:0] conv_data,
  input  wire logic [5:0]  coef_raddr,
  output logic [26:0]      coef_rdata,
  output logic             user_filter,
  output logic [15:0]      ctrl_out,
  output logic             busy
);
  // two entry input buffer
  logic [15:0] buf_reg [0:1];
  logic [15:0] buf_next [0:1];
  logic [1:0]  cnt_reg, cnt_next;
  logic        buf_pop;
  fcl_pkg::fcl_state_t st_reg, st_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] sum_reg, sum_next;
  logic [5:0]  idx_reg, idx_next, ncoef_reg, ncoef_next;
  logic [10:0] hi_reg, hi_next;
  logic        match_reg, match_next, user_reg, user_next, stat_sel_reg, stat_sel_next;
  logic        hit_reg, hit_next; // last address word named control 1
  logic [15:0] rd_data_reg, rd_data_next;
  logic        rd_valid_reg, rd_valid_next;
  logic        we;
  logic [5:0]  waddr;
  logic [26:0] wdata;
  logic [15:0] head;
  logic [15:0] status;

  assign head = buf_reg[0];
  // buffer stalls the host while the sequencer zero fills
  assign buf_pop = (cnt_reg != 2'd0) && (st_reg != fcl_pkg::FCL_FILL);

  // buffer next state
  always_comb begin
    buf_next[0] = buf_reg[0];
    buf_next[1] = buf_reg[1];
    cnt_next    = cnt_reg;
    if (buf_pop) begin
      buf_next[0] = buf_reg[1];
      cnt_next    = cnt_next - 2'd1;
    end
    if (wr_valid && wr_ready) begin
      buf_next[cnt_next[0]] = wr_data;
      cnt_next              = cnt_next + 2'd1;
    end
  end

  // buffer registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buf_reg[0] <= 16'h0000;
      buf_reg[1] <= 16'h0000;
      cnt_reg    <= 2'd0;
      wr_ready   <= 1'b0;
    end else begin
      buf_reg[0] <= buf_next[0];
      buf_reg[1] <= buf_next[1];
      cnt_reg    <= cnt_next;
      // ready is registered, so it looks one entry ahead to stay safe
      wr_ready   <= (cnt_next == 2'd0);
    end
  end

  // status word; part and die fields unmodelled, read zero
  always_comb begin
    status = 16'h0000;
    status[`FCL_BIT_MATCH] = match_reg; // R9
    status[`FCL_BIT_USER]  = user_reg;
    status[4:0]            = ctrl_reg[4:0];
  end

  // sequencer next state
  always_comb begin
    st_next       = st_reg;
    ctrl_next     = ctrl_reg & `FCL_SELF_CLR_MASK; // R20
    sum_next      = sum_reg;
    idx_next      = idx_reg;
    ncoef_next    = ncoef_reg;
    hi_next       = hi_reg;
    match_next    = match_reg;
    user_next     = user_reg;
    stat_sel_next = stat_sel_reg;
    hit_next      = hit_reg;
    rd_data_next  = rd_data_reg;
    rd_valid_next = 1'b0;
    we            = 1'b0;
    waddr         = idx_reg;
    wdata         = 27'h0000000;
    if (rd_strobe) begin
      rd_data_next  = stat_sel_reg ? status : conv_data; // R18 R21
      rd_valid_next = 1'b1;
      stat_sel_next = 1'b0;
    end
    case (st_reg)
      fcl_pkg::FCL_ADDR: begin
        // every address word owns the next word, mapped or not, so pairs never slip R16
        if (buf_pop) begin
          hit_next = (head == `FCL_CTRL1_ADDR); // R17
          st_next  = fcl_pkg::FCL_DATA;
        end
      end
      fcl_pkg::FCL_DATA: begin
        if (buf_pop) begin
          st_next = fcl_pkg::FCL_ADDR;
        end
        // data for registers outside this block is dropped here
        if (buf_pop && hit_reg) begin
          ctrl_next = head & `FCL_SELF_CLR_MASK; // R20
          if (head[`FCL_BIT_RD_STAT]) begin
            stat_sel_next = 1'b1; // R21
          end
          if (head[`FCL_BIT_LOAD_REQ]) begin // R10
            if (head[`FCL_TAP_HI:`FCL_TAP_LO] == 4'h0) begin
              user_next = 1'b0; // R14
            end else begin
              // even codes round down to the odd code below; count = (code+1)/2 * 6 R14
              ncoef_next = 6'((head[`FCL_TAP_HI:`FCL_TAP_LO] + 5'd1) >> 1) * 6'(`FCL_COEF_STEP);
              idx_next   = 6'd0;
              sum_next   = 16'h0000;
              match_next = 1'b0; // R24
              user_next  = 1'b0;
              st_next    = fcl_pkg::FCL_COEF_HI; // R19
            end
          end
        end
      end
      fcl_pkg::FCL_COEF_HI: begin
        if (buf_pop) begin
          hi_next  = head[10:0]; // R2 R7 sign sits in bit 10
          sum_next = 16'(sum_reg + {8'h00, head[15:8]} + {8'h00, head[7:0]}); // R8 R23
          st_next  = fcl_pkg::FCL_COEF_LO;
        end
      end
      fcl_pkg::FCL_COEF_LO: begin
        if (buf_pop) begin
          we       = 1'b1;
          waddr    = idx_reg; // R5 slot 0 is next to the centre
          wdata    = {hi_reg, head}; // R2 R7
          sum_next = 16'(sum_reg + {8'h00, head[15:8]} + {8'h00, head[7:0]}); // R8 R23
          idx_next = 6'(idx_reg + 6'd1);
          st_next  = (6'(idx_reg + 6'd1) == ncoef_reg) ? fcl_pkg::FCL_CHECK : fcl_pkg::FCL_COEF_HI;
        end
      end
      fcl_pkg::FCL_CHECK: begin
        if (buf_pop) begin
          match_next = (head == sum_reg); // R9
          user_next  = 1'b1;
          st_next    = (idx_reg == 6'(`FCL_MAX_COEF)) ? fcl_pkg::FCL_ADDR : fcl_pkg::FCL_FILL;
        end
      end
      fcl_pkg::FCL_FILL: begin
        // one slot per cycle, a full clock per slot against the half clock per slot budget R15
        we       = 1'b1;
        waddr    = idx_reg;
        wdata    = 27'h0000000;
        idx_next = 6'(idx_reg + 6'd1);
        if (idx_reg == 6'(`FCL_MAX_COEF - 1)) begin
          st_next = fcl_pkg::FCL_ADDR;
        end
      end
      default: st_next = fcl_pkg::FCL_ADDR;
    endcase
  end

  // sequencer registers; reset drops the user filter R13
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg       <= fcl_pkg::FCL_ADDR;
      ctrl_reg     <= `FCL_CTRL1_RESET; // R17
      sum_reg      <= 16'h0000;
      idx_reg      <= 6'd0;
      ncoef_reg    <= 6'd0;
      hi_reg       <= 11'h000;
      match_reg    <= 1'b0;
      user_reg     <= 1'b0; // R13
      stat_sel_reg <= 1'b0;
      hit_reg      <= 1'b0;
      rd_data_reg  <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else begin
      st_reg       <= st_next;
      ctrl_reg     <= ctrl_next;
      sum_reg      <= sum_next;
      idx_reg      <= idx_next;
      ncoef_reg    <= ncoef_next;
      hi_reg       <= hi_next;
      match_reg    <= match_next;
      user_reg     <= user_next;
      stat_sel_reg <= stat_sel_next;
      hit_reg      <= hit_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // outputs straight from flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      user_filter <= 1'b0;
      ctrl_out    <= `FCL_CTRL1_RESET;
      busy        <= 1'b0;
    end else begin
      user_filter <= user_next; // R4 datapath mirrors the stored half
      ctrl_out    <= ctrl_next;
      busy        <= (st_next != fcl_pkg::FCL_ADDR) && (st_next != fcl_pkg::FCL_DATA);
    end
  end

  assign rd_data  = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  fcl_coef_ram u_ram (
    .clock (clock),
    .we    (we),
    .waddr (waddr),
    .wdata (wdata),
    .raddr (coef_raddr),
    .rdata (coef_rdata)
  );
endmodule : fcl_loader

/* tb/fcl_loader_asserts.sv */
// port assertions for the fir coefficient loader
`timescale 1ns/1ps
module fcl_loader_asserts (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic        rd_strobe,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic        user_filter,
  input wire logic [15:0] ctrl_out,
  input wire logic        busy
);
  logic acc;
  // a word is taken only when both sides agree
  assign acc = wr_valid && wr_ready;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // four idle cycles outside the zero fill: every taken word has been processed
  sequence s_quiet;
    !acc [*4];
  endsequence
  a_reset_values: assert property (disable iff (1'b0) !rst_n |=>
    ctrl_out == 16'h001A && !user_filter && !busy && !wr_ready) else $error("reset values wrong");
  a_ready_release: assert property ($rose(rst_n) |=> wr_ready) else $error("no ready after reset");
  a_self_clear: assert property (ctrl_out[15:9] == 7'h00)
    else $error("self clearing bits stuck");
  a_read_answer: assert property (rd_strobe |=> rd_valid)
    else $error("read not answered");
  a_read_pulse: assert property (!rd_strobe |=> !rd_valid)
    else $error("read valid without strobe");
  a_read_hold: assert property (!rd_strobe |=> $stable(rd_data))
    else $error("read data moved");
  a_ctrl_hold: assert property (s_quiet |=> $stable(ctrl_out))
    else $error("control moved without write");
  a_user_hold: assert property (s_quiet |=> $stable(user_filter))
    else $error("user flag moved without write");
endmodule : fcl_loader_asserts
bind fcl_loader fcl_loader_asserts fcl_loader_asserts_i (.clock, .rst_n, .wr_valid, .wr_ready, .rd_strobe,
  .rd_valid, .rd_data, .user_filter, .ctrl_out, .busy);

/* tb/fcl_host.sv */
// host model driving the loader write port
`timescale 1ns/1ps
module fcl_host (
  input  wire logic        clock,
  input  wire logic        wr_ready,
  output logic             wr_valid,
  output logic [15:0]      wr_data
);
  initial begin
    wr_valid = 1'b0;
    wr_data  = 16'h0000;
  end
  // coefficient k: sign alternates, magnitude spread wide
  function automatic logic [26:0] cf(input int k);
    cf = {k[0], 26'(k * 9973 + 1)};
  endfunction : cf
  // word held until taken; a stall just stretches it
  task automatic put(input logic [15:0] w);
    wr_data = w;
    wr_valid = 1'b1;
    // ready is read at the falling edge, settled for the rise that takes the word
    @(negedge clock);
    while (wr_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    #1;
  endtask : put
  // released line shows the inverse, never a stale word
  task automatic idle();
    wr_valid = 1'b0;
    wr_data = ~wr_data;
  endtask : idle
  // arm, send n coefficients centre first, then the checksum
  task automatic load(input logic [3:0] code, input int n, input logic bad);
    logic [15:0] sum;
    logic [31:0] p;
    sum = 16'h0000;
    put(16'h0001);
    put({1'b1, 6'h00, code, 5'h1A});
    for (int k = 0; k < n; k++) begin
      p = {5'h00, cf(k)};
      put(p[31:16]);
      put(p[15:0]);
      sum = sum + p[31:24] + p[23:16] + p[15:8] + p[7:0];
    end
    put(sum + {15'h0000, bad});
    idle();
  endtask : load
endmodule : fcl_host

/* tb/fcl_loader_tb.sv */
// testbench for the fir coefficient loader
`timescale 1ns/1ps
module fcl_loader_tb;
  logic        clock, rst_n, wr_valid, wr_ready, rd_strobe, rd_valid, user_filter, busy;
  logic [15:0] wr_data, rd_data, ctrl_out, conv_data;
  logic [5:0]  coef_raddr;
  logic [26:0] coef_rdata;
  int          errors, checks;
  fcl_loader fcl_loader_i (.clock, .rst_n, .wr_valid, .wr_ready, .wr_data, .rd_strobe, .rd_data, .rd_valid,
    .conv_data, .coef_raddr, .coef_rdata, .user_filter, .ctrl_out, .busy);
  fcl_host fcl_host_i (.clock, .wr_ready, .wr_valid, .wr_data);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // one read; strobe low for a cycle after so reads never abut
  task automatic rd(output logic [15:0] d);
    rd_strobe = 1'b1;
    cyc(1);
    rd_strobe = 1'b0;
    chk(rd_valid, 1'b1);
    d = rd_data;
    cyc(1);
  endtask : rd
  task automatic stat(input logic [3:0] code, output logic [15:0] d);
    fcl_host_i.put(16'h0001);
    fcl_host_i.put({5'h01, 2'h0, code, 5'h1A});
    fcl_host_i.idle();
    cyc(4);
    rd(d);
  endtask : stat
  // watchdog, far beyond the longest run of loads
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    stop_test();
  end
  initial begin
    logic [15:0] d;
    int n;
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    rd_strobe = 1'b0;
    coef_raddr = 6'h00;
    conv_data = 16'h5A5A;
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
    chk(ctrl_out, 16'h001A);
    // every odd tap code, 6 to 48 coefficients
    for (int c = 1; c < 16; c += 2) begin
      n = 3 * (c + 1);
      conv_data = 16'h5A5A ^ 16'(c);
      fcl_host_i.load(4'(c), n, 1'b0);
      chk(busy, 1'b1);
      while (busy !== 1'b0) cyc(1);
      cyc(4);
      chk(ctrl_out, {7'h00, 4'(c), 5'h1A});
      stat(4'(c), d);
      chk({d[7], d[5]}, 2'h3);
      coef_raddr = 6'(n - 1);
      cyc(2);
      chk(coef_rdata, fcl_host_i.cf(n - 1));
      coef_raddr = 6'h00;
      cyc(2);
      chk(coef_rdata, fcl_host_i.cf(0));
      coef_raddr = 6'(n % 48);
      cyc(2);
      if (n < 48) chk(coef_rdata, 27'h0000000);
      rd(d);
      chk(d, conv_data);
    end
    fcl_host_i.load(4'h1, 6, 1'b1);
    while (busy !== 1'b0) cyc(1);
    stat(4'h1, d);
    chk({d[7], user_filter}, 2'h1);
    // unmapped address is ignored
    fcl_host_i.put(16'h0005);
    fcl_host_i.put(16'h0001);
    fcl_host_i.put(16'h0001);
    fcl_host_i.put(16'h801A);
    fcl_host_i.idle();
    cyc(4);
    chk({ctrl_out, user_filter}, 17'h00034);
    // good load first, so the cut load and reset have a flag to clear
    fcl_host_i.load(4'h1, 6, 1'b0);
    while (busy !== 1'b0) cyc(1);
    // load cut short by reset
    fcl_host_i.put(16'h0001);
    fcl_host_i.put(16'h803A);
    fcl_host_i.put(16'h0001);
    fcl_host_i.idle();
    cyc(2);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    chk({ctrl_out, user_filter}, 17'h00034);
    stat(4'h0, d);
    chk({d[7], d[5]}, 2'h0);
    stop_test();
  end
endmodule : fcl_loader_tb
